// ---- pkg/bfb_pkg.sv ----
// Shared constants of the bypass and host-port control block.
package bfb_pkg;
    localparam int DATA_W = 18;
    localparam logic [2:0] SEL_FIFO = 3'h0;
    localparam logic [2:0] SEL_BYPASS = 3'h1;
    localparam int SEL_OFFSET_BIT = 2;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic TGL_RST = 1'b0;
    localparam logic MODE_RST = 1'b0;
    localparam logic RW_RST = 1'b0;
endpackage

// ---- rtl/bfb_ctrl.sv ----
// Bypass paths and host port control of a two-clock bidirectional FIFO.
`timescale 1ns/1ns
`default_nettype none
module bfb_ctrl
    import bfb_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic peer_clock_i,
    input wire logic host_select_n_i,
    input wire logic [2:0] host_resource_sel_i,
    input wire logic host_read_not_write_i,
    input wire logic host_xfer_enable_n_i,
    input wire logic host_bus_drive_n_i,
    input wire logic [DATA_W-1:0] host_data_bus_i,
    output logic [DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic fwd_full_n_o,
    output logic rev_empty_n_o,
    output logic fwd_fifo_wr_o,
    output logic [DATA_W-1:0] fwd_fifo_wdata_o,
    output logic rev_fifo_rd_o,
    input wire logic [DATA_W-1:0] rev_fifo_rdata_i,
    output logic [1:0] offset_sel_o,
    input wire logic [DATA_W-1:0] offset_value_i,
    input wire logic peer_read_not_write_i,
    input wire logic peer_xfer_enable_n_i,
    input wire logic peer_bus_drive_n_i,
    input wire logic [DATA_W-1:0] peer_data_bus_i,
    output logic [DATA_W-1:0] peer_data_bus_o,
    output logic peer_data_bus_oe_o,
    output logic bypass_indicator_n_o,
    output logic fwd_empty_n_o,
    output logic rev_full_n_o,
    output logic fwd_fifo_rd_o,
    input wire logic [DATA_W-1:0] fwd_fifo_rdata_i,
    output logic rev_fifo_wr_o,
    output logic [DATA_W-1:0] rev_fifo_wdata_o
);

    function automatic logic xfer(input logic rw, input logic en_n, input logic want_read);
        return (rw == want_read) && !en_n;
    endfunction

    logic host_bypass;
    logic host_rw_q;
    logic [DATA_W-1:0] fwd_word;
    logic fwd_wr_tgl;
    logic fwd_ack_s1;
    logic fwd_ack_s2;
    logic rev_wr_s1;
    logic rev_wr_s2;
    logic rev_ack_tgl;
    logic byp_s1;
    logic byp_s2;
    logic peer_rw_q;
    logic [DATA_W-1:0] rev_word;
    logic rev_wr_tgl;
    logic rev_ack_s1;
    logic rev_ack_s2;
    logic fwd_wr_s1;
    logic fwd_wr_s2;
    logic fwd_rd_tgl;
    logic host_rd_go;
    logic host_wr_go;
    logic host_sel_fifo;
    logic host_sel_byp;
    logic host_leave;
    logic peer_rd_go;
    logic peer_wr_go;

    // Host command decode; reads and writes are gated off while the host port is deselected, but deselect still ends bypass mode.
    assign host_rd_go = !host_select_n_i &&
        xfer(host_read_not_write_i, host_xfer_enable_n_i, 1'b1);
    assign host_wr_go = !host_select_n_i &&
        xfer(host_read_not_write_i, host_xfer_enable_n_i, 1'b0);
    assign host_sel_fifo = host_resource_sel_i == SEL_FIFO;
    assign host_sel_byp = host_resource_sel_i == SEL_BYPASS;
    assign host_leave = host_select_n_i || host_sel_fifo;
    assign peer_rd_go = xfer(peer_read_not_write_i, peer_xfer_enable_n_i, 1'b1);
    assign peer_wr_go = xfer(peer_read_not_write_i, peer_xfer_enable_n_i, 1'b0);

    // Host mode: entered at address 001, left at address 000 or on deselect.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_bypass <= MODE_RST;
        end else if (host_leave) begin
            host_bypass <= 1'b0;
        end else if (host_sel_byp) begin
            host_bypass <= 1'b1;
        end
    end

    // Host write path: FIFO word or one-word forward bypass.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fwd_word <= DATA_RST;
            fwd_wr_tgl <= TGL_RST;
            fwd_fifo_wr_o <= 1'b0;
        end else begin
            fwd_fifo_wr_o <= host_wr_go && host_sel_fifo;
            if (host_wr_go && host_sel_fifo) begin
                fwd_word <= host_data_bus_i;
            end else if (host_wr_go && host_sel_byp && fwd_full_n_o) begin
                fwd_word <= host_data_bus_i;
                fwd_wr_tgl <= !fwd_wr_tgl;
            end
        end
    end

    assign fwd_fifo_wdata_o = fwd_word;

    // Peer read acknowledge and reverse write toggle cross back into the host domain.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fwd_ack_s1 <= TGL_RST;
            fwd_ack_s2 <= TGL_RST;
            rev_wr_s1 <= TGL_RST;
            rev_wr_s2 <= TGL_RST;
        end else begin
            fwd_ack_s1 <= fwd_rd_tgl;
            fwd_ack_s2 <= fwd_ack_s1;
            rev_wr_s1 <= rev_wr_tgl;
            rev_wr_s2 <= rev_wr_s1;
        end
    end

    assign fwd_full_n_o = fwd_wr_tgl == fwd_ack_s2;
    assign rev_empty_n_o = rev_wr_s2 != rev_ack_tgl;

    // Host read path into the host output register.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_data_bus_o <= DATA_RST;
            rev_ack_tgl <= TGL_RST;
        end else if (host_rd_go && host_resource_sel_i[SEL_OFFSET_BIT]) begin
            host_data_bus_o <= offset_value_i;
        end else if (host_rd_go && host_sel_fifo) begin
            host_data_bus_o <= rev_fifo_rdata_i;
        end else if (host_rd_go && host_sel_byp && rev_empty_n_o) begin
            host_data_bus_o <= rev_word;
            rev_ack_tgl <= !rev_ack_tgl;
        end else if (host_leave && rev_empty_n_o) begin
            rev_ack_tgl <= !rev_ack_tgl;
        end
    end

    assign rev_fifo_rd_o = host_rd_go && host_sel_fifo;
    assign offset_sel_o = host_resource_sel_i[1:0];

    // Sampled direction level; a write level releases the bus next cycle.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_rw_q <= RW_RST;
        end else begin
            host_rw_q <= host_read_not_write_i;
        end
    end

    assign host_data_bus_oe_o = !host_select_n_i && !host_bus_drive_n_i &&
        host_rw_q;

    // Peer domain synchronisers for mode, forward write toggle and reverse read acknowledge.
    always_ff @(posedge peer_clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            byp_s1 <= MODE_RST;
            byp_s2 <= MODE_RST;
            fwd_wr_s1 <= TGL_RST;
            fwd_wr_s2 <= TGL_RST;
            rev_ack_s1 <= TGL_RST;
            rev_ack_s2 <= TGL_RST;
        end else begin
            byp_s1 <= host_bypass;
            byp_s2 <= byp_s1;
            fwd_wr_s1 <= fwd_wr_tgl;
            fwd_wr_s2 <= fwd_wr_s1;
            rev_ack_s1 <= rev_ack_tgl;
            rev_ack_s2 <= rev_ack_s1;
        end
    end

    assign bypass_indicator_n_o = !byp_s2;
    assign fwd_empty_n_o = fwd_wr_s2 != fwd_rd_tgl;
    assign rev_full_n_o = rev_wr_tgl == rev_ack_s2;
    assign fwd_fifo_rd_o = peer_rd_go && !byp_s2;

    // Peer read path into the peer output register.
    always_ff @(posedge peer_clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            peer_data_bus_o <= DATA_RST;
            fwd_rd_tgl <= TGL_RST;
        end else if (!byp_s2) begin
            if (peer_rd_go) begin
                peer_data_bus_o <= fwd_fifo_rdata_i;
            end
            if (fwd_empty_n_o) begin
                fwd_rd_tgl <= !fwd_rd_tgl;
            end
        end else if (peer_rd_go && fwd_empty_n_o) begin
            peer_data_bus_o <= fwd_word;
            fwd_rd_tgl <= !fwd_rd_tgl;
        end
    end

    // Peer write path: FIFO word or one-word reverse bypass.
    always_ff @(posedge peer_clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rev_word <= DATA_RST;
            rev_wr_tgl <= TGL_RST;
            rev_fifo_wr_o <= 1'b0;
        end else begin
            rev_fifo_wr_o <= peer_wr_go && !byp_s2;
            if (peer_wr_go && !byp_s2) begin
                rev_word <= peer_data_bus_i;
            end else if (peer_wr_go && rev_full_n_o) begin
                rev_word <= peer_data_bus_i;
                rev_wr_tgl <= !rev_wr_tgl;
            end
        end
    end

    assign rev_fifo_wdata_o = rev_word;

    always_ff @(posedge peer_clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            peer_rw_q <= RW_RST;
        end else begin
            peer_rw_q <= peer_read_not_write_i;
        end
    end

    assign peer_data_bus_oe_o = !peer_bus_drive_n_i && peer_rw_q;

    sequence s_host_byp_write;
        host_wr_go && host_sel_byp && fwd_full_n_o;
    endsequence

    sequence s_host_byp_read;
        host_rd_go && host_sel_byp && rev_empty_n_o;
    endsequence

    sequence s_peer_byp_read;
        byp_s2 && peer_rd_go && fwd_empty_n_o;
    endsequence

    sequence s_peer_byp_write;
        byp_s2 && peer_wr_go && rev_full_n_o;
    endsequence

    sequence s_host_leave_pending;
        host_leave && rev_empty_n_o && !host_rd_go;
    endsequence

    a_fwd_full_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_host_byp_write |=> !fwd_full_n_o && fwd_word == $past(host_data_bus_i))
        else $error("forward full flag did not drop after bypass write");

    a_fwd_write_block: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_wr_go && host_sel_byp && !fwd_full_n_o |=> $stable(fwd_wr_tgl))
        else $error("bypass write accepted while forward path full");

    a_host_deselect_hiz: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_select_n_i |-> !host_data_bus_oe_o ##1 !fwd_fifo_wr_o)
        else $error("host bus driven or FIFO written while deselected");

    a_host_rw_hiz: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !host_read_not_write_i |=> !host_data_bus_oe_o)
        else $error("host bus driven after sampled write level");

    a_host_idle_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !host_select_n_i && host_read_not_write_i && host_xfer_enable_n_i
        |-> !rev_fifo_rd_o ##1 $stable(host_data_bus_o))
        else $error("host output changed on disabled read");

    a_host_fifo_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_rd_go && host_sel_fifo
        |-> rev_fifo_rd_o ##1 host_data_bus_o == $past(rev_fifo_rdata_i))
        else $error("reverse FIFO word not loaded on host read");

    a_host_offset_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_rd_go && host_resource_sel_i[SEL_OFFSET_BIT]
        |-> offset_sel_o == host_resource_sel_i[1:0] ##1
        host_data_bus_o == $past(offset_value_i))
        else $error("offset value not loaded on host read");

    a_host_fifo_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_wr_go && host_sel_fifo
        |=> fwd_fifo_wr_o && fwd_fifo_wdata_o == $past(host_data_bus_i))
        else $error("host FIFO write not issued");

    a_rev_empty_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_host_byp_read |=> !rev_empty_n_o && host_data_bus_o == $past(rev_word))
        else $error("reverse bypass read did not empty the path");

    a_fwd_peer_read: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        s_peer_byp_read |=> !fwd_empty_n_o && peer_data_bus_o == $past(fwd_word))
        else $error("peer bypass read did not load word and empty path");

    a_fwd_arrive: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        byp_s2 && $changed(fwd_wr_s2) |-> fwd_empty_n_o)
        else $error("forward word arrived without empty flag rising");

    a_fwd_discard: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        !byp_s2 && fwd_empty_n_o ##1 !byp_s2 |-> !fwd_empty_n_o)
        else $error("pending forward word kept after bypass ended");

    a_peer_fifo_write: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        peer_wr_go && bypass_indicator_n_o
        |=> rev_fifo_wr_o && rev_fifo_wdata_o == $past(peer_data_bus_i))
        else $error("peer FIFO write not issued");

    a_host_mode_enter: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !host_leave && host_sel_byp |=> host_bypass)
        else $error("host did not enter bypass mode");

    a_host_mode_leave: assert property (@(posedge clock_i) disable iff (!rstn_i)
        host_leave |=> !host_bypass)
        else $error("host did not leave bypass mode");

    a_byp_ind_low: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        host_bypass |-> ##2 !bypass_indicator_n_o)
        else $error("bypass indicator did not fall");

    a_byp_ind_high: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        !host_bypass |-> ##2 bypass_indicator_n_o)
        else $error("bypass indicator did not rise");

    a_fwd_full_return: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $changed(fwd_ack_s2) |-> fwd_full_n_o)
        else $error("forward full flag did not return after peer read");

    a_rev_full_drop: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        s_peer_byp_write |=> !rev_full_n_o && rev_word == $past(peer_data_bus_i))
        else $error("reverse full flag did not drop after bypass write");

    a_rev_write_block: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        byp_s2 && peer_wr_go && !rev_full_n_o |=> $stable(rev_wr_tgl))
        else $error("bypass write accepted while reverse path full");

    a_rev_discard: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_host_leave_pending |=> !rev_empty_n_o)
        else $error("pending reverse word kept after bypass ended");

    a_peer_rw_hiz: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        !peer_read_not_write_i |=> !peer_data_bus_oe_o)
        else $error("peer bus driven after sampled write level");

    a_peer_fifo_read: assert property (@(posedge peer_clock_i) disable iff (!rstn_i)
        peer_rd_go && !byp_s2
        |-> fwd_fifo_rd_o ##1 peer_data_bus_o == $past(fwd_fifo_rdata_i))
        else $error("forward FIFO word not loaded on peer read");

endmodule
`default_nettype wire

// ---- verif/bfb_far_model.sv ----
// Behavioural model of the FIFO arrays and offset registers beside the block.
`timescale 1ns/1ns
`default_nettype none
module bfb_far_model
    import bfb_pkg::*;
(
    input wire logic clock_i,
    input wire logic peer_clock_i,
    input wire logic rstn_i,
    input wire logic fwd_wr_i,
    input wire logic [DATA_W-1:0] fwd_wdata_i,
    input wire logic fwd_rd_i,
    input wire logic rev_wr_i,
    input wire logic [DATA_W-1:0] rev_wdata_i,
    input wire logic rev_rd_i,
    input wire logic [1:0] offset_sel_i,
    output logic [DATA_W-1:0] fwd_rdata_o,
    output logic [DATA_W-1:0] rev_rdata_o,
    output logic [DATA_W-1:0] offset_value_o
);
    logic [DATA_W-1:0] fwd_mem [4];
    logic [DATA_W-1:0] rev_mem [4];
    logic [1:0] fwd_wp, fwd_rp, rev_wp, rev_rp;
    // Host clock writes the forward array and reads the reverse one.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fwd_wp <= 2'h0;
            rev_rp <= 2'h0;
        end else begin
            if (fwd_wr_i) begin
                fwd_mem[fwd_wp] <= fwd_wdata_i;
                fwd_wp <= fwd_wp + 2'h1;
            end
            if (rev_rd_i) begin
                rev_rp <= rev_rp + 2'h1;
            end
        end
    end
    // Peer clock writes the reverse array and reads the forward one.
    always_ff @(posedge peer_clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rev_wp <= 2'h0;
            fwd_rp <= 2'h0;
        end else begin
            if (rev_wr_i) begin
                rev_mem[rev_wp] <= rev_wdata_i;
                rev_wp <= rev_wp + 2'h1;
            end
            if (fwd_rd_i) begin
                fwd_rp <= fwd_rp + 2'h1;
            end
        end
    end
    assign fwd_rdata_o = fwd_mem[fwd_rp];
    assign rev_rdata_o = rev_mem[rev_rp];
    assign offset_value_o = 18'h00008 + {16'h0000, offset_sel_i};
endmodule
`default_nettype wire

// ---- verif/bfb_ctrl_tb.sv ----
// Self-checking bench of the bypass and host port control block.
`timescale 1ns/1ns
`default_nettype none
module bfb_ctrl_tb
    import bfb_pkg::*;
;
    logic clock_i = 1'b0;
    logic peer_clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cs_n = 1'b1;
    logic [2:0] sel = 3'h0;
    logic rw = 1'b1;
    logic en_n = 1'b1;
    logic drv_n = 1'b1;
    logic [DATA_W-1:0] hdin = 18'h00000;
    logic prw = 1'b1;
    logic pen_n = 1'b1;
    logic pdrv_n = 1'b1;
    logic [DATA_W-1:0] pdin = 18'h00000;
    logic [DATA_W-1:0] hdo, fwd_wd, pdo, rev_wd, frdata, rrdata, oval;
    logic hoe, ffull, rempty, fwr, rrd, poe, byp_n, fempty, rfull, frd, rwr;
    logic [1:0] osel;
    logic [4:0] flags;
    int miscompares = 0;
    int compares = 0;
    assign flags = {rempty, rfull, fempty, ffull, byp_n};
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    initial begin
        #7;
        forever #16 peer_clock_i = ~peer_clock_i;
    end
    bfb_ctrl i_bfb_ctrl (.clock_i(clock_i), .rstn_i(rstn_i), .peer_clock_i(peer_clock_i),
        .host_select_n_i(cs_n), .host_resource_sel_i(sel), .host_read_not_write_i(rw),
        .host_xfer_enable_n_i(en_n), .host_bus_drive_n_i(drv_n), .host_data_bus_i(hdin),
        .host_data_bus_o(hdo), .host_data_bus_oe_o(hoe), .fwd_full_n_o(ffull),
        .rev_empty_n_o(rempty), .fwd_fifo_wr_o(fwr), .fwd_fifo_wdata_o(fwd_wd),
        .rev_fifo_rd_o(rrd), .rev_fifo_rdata_i(rrdata), .offset_sel_o(osel),
        .offset_value_i(oval), .peer_read_not_write_i(prw), .peer_xfer_enable_n_i(pen_n),
        .peer_bus_drive_n_i(pdrv_n), .peer_data_bus_i(pdin), .peer_data_bus_o(pdo),
        .peer_data_bus_oe_o(poe), .bypass_indicator_n_o(byp_n), .fwd_empty_n_o(fempty),
        .rev_full_n_o(rfull), .fwd_fifo_rd_o(frd), .fwd_fifo_rdata_i(frdata),
        .rev_fifo_wr_o(rwr), .rev_fifo_wdata_o(rev_wd));
    bfb_far_model i_bfb_far_model (.clock_i(clock_i), .peer_clock_i(peer_clock_i),
        .rstn_i(rstn_i), .fwd_wr_i(fwr), .fwd_wdata_i(fwd_wd), .fwd_rd_i(frd),
        .rev_wr_i(rwr), .rev_wdata_i(rev_wd), .rev_rd_i(rrd), .offset_sel_i(osel),
        .fwd_rdata_o(frdata), .rev_rdata_o(rrdata), .offset_value_o(oval));
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One host transfer: controls set after a falling edge, enable dropped after the next.
    task automatic host_op(input logic [2:0] s, input logic r, input logic [DATA_W-1:0] d,
                           input logic e);
        @(negedge clock_i);
        cs_n = 1'b0;
        sel = s;
        rw = r;
        hdin = d;
        en_n = e;
        @(negedge clock_i);
        en_n = 1'b1;
    endtask
    task automatic peer_op(input logic r, input logic dv, input logic [DATA_W-1:0] d);
        @(negedge peer_clock_i);
        prw = r;
        pdrv_n = dv;
        pdin = d;
        pen_n = 1'b0;
        @(negedge peer_clock_i);
        pen_n = 1'b1;
    endtask
    task automatic wait_flag(input int k, input logic v);
        int i;
        for (i = 0; i < 40 && flags[k] !== v; i++) begin
            @(negedge clock_i);
        end
        chk({17'h00000, flags[k]}, {17'h00000, v});
        if (flags[k] !== v) begin
            report_and_stop();
        end
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        rstn_i = 1'b1;
        chk({13'h0000, flags}, 18'h0000B);
        host_op(SEL_FIFO, 1'b0, 18'h01234, 1'b0);
        chk({17'h00000, fwr}, 18'h00001);
        chk(fwd_wd, 18'h01234);
        peer_op(1'b1, 1'b0, 18'h00000);
        chk(pdo, 18'h01234);
        chk({17'h00000, poe}, 18'h00001);
        peer_op(1'b0, 1'b1, 18'h0ABCD);
        chk({17'h00000, rwr}, 18'h00001);
        chk(rev_wd, 18'h0ABCD);
        repeat (2) @(negedge peer_clock_i);
        host_op(SEL_FIFO, 1'b1, 18'h00000, 1'b0);
        chk(hdo, 18'h0ABCD);
        host_op(SEL_FIFO, 1'b1, 18'h00000, 1'b1);
        chk(hdo, 18'h0ABCD);
        for (int k = 0; k < 4; k++) begin
            host_op(3'h4 | 3'(k), 1'b1, 18'h00000, 1'b0);
            chk(hdo, 18'h00008 + 18'(k));
        end
        drv_n = 1'b0;
        #1;
        chk({17'h00000, hoe}, 18'h00001);
        drv_n = 1'b1;
        #1;
        chk({17'h00000, hoe}, 18'h00000);
        @(negedge clock_i);
        rw = 1'b0;
        @(negedge clock_i);
        drv_n = 1'b0;
        host_op(SEL_FIFO, 1'b0, 18'h00000, 1'b1);
        chk({17'h00000, hoe}, 18'h00000);
        chk({17'h00000, fwr}, 18'h00000);
        drv_n = 1'b1;
        host_op(SEL_BYPASS, 1'b0, 18'h00000, 1'b1);
        wait_flag(0, 1'b0);
        host_op(SEL_BYPASS, 1'b0, 18'h2AAAA, 1'b0);
        chk({17'h00000, ffull}, 18'h00000);
        host_op(SEL_BYPASS, 1'b0, 18'h11111, 1'b0);
        peer_op(1'b0, 1'b1, 18'h35555);
        chk({17'h00000, rfull}, 18'h00000);
        peer_op(1'b0, 1'b1, 18'h3F0F0);
        wait_flag(2, 1'b1);
        wait_flag(4, 1'b1);
        fork
            host_op(SEL_BYPASS, 1'b1, 18'h00000, 1'b0);
            peer_op(1'b1, 1'b0, 18'h00000);
        join
        chk(pdo, 18'h2AAAA);
        chk(hdo, 18'h35555);
        chk({17'h00000, fempty}, 18'h00000);
        wait_flag(1, 1'b1);
        wait_flag(3, 1'b1);
        host_op(SEL_BYPASS, 1'b0, 18'h12345, 1'b0);
        peer_op(1'b0, 1'b1, 18'h0F00F);
        wait_flag(2, 1'b1);
        wait_flag(4, 1'b1);
        host_op(SEL_FIFO, 1'b1, 18'h00000, 1'b1);
        chk({17'h00000, rempty}, 18'h00000);
        wait_flag(0, 1'b1);
        wait_flag(2, 1'b0);
        wait_flag(1, 1'b1);
        wait_flag(3, 1'b1);
        host_op(SEL_FIFO, 1'b0, 18'h0F0F0, 1'b0);
        @(negedge clock_i);
        peer_op(1'b1, 1'b0, 18'h00000);
        chk(pdo, 18'h0F0F0);
        host_op(SEL_BYPASS, 1'b0, 18'h00000, 1'b1);
        wait_flag(0, 1'b0);
        peer_op(1'b0, 1'b1, 18'h0C3C3);
        wait_flag(4, 1'b1);
        @(negedge clock_i);
        cs_n = 1'b1;
        rw = 1'b1;
        drv_n = 1'b0;
        wait_flag(0, 1'b1);
        chk({17'h00000, rempty}, 18'h00000);
        chk({17'h00000, hoe}, 18'h00000);
        rw = 1'b0;
        en_n = 1'b0;
        @(negedge clock_i);
        en_n = 1'b1;
        chk({17'h00000, fwr}, 18'h00000);
        report_and_stop();
    end
endmodule
`default_nettype wire
